// *** duhb_params.svh ***
// constants for the dual serial controller host bus and pin map
// assumes inclusion by duhb_pkg and the top module
`ifndef DUHB_PARAMS_SVH
`define DUHB_PARAMS_SVH

// register addresses on the four address lines
`define DUHB_A_MODE_A    4'h0
`define DUHB_A_STAT_A    4'h1
`define DUHB_A_CMD_A     4'h2
`define DUHB_A_DATA_A    4'h3
`define DUHB_A_IPCR      4'h4
`define DUHB_A_ISR_IMR   4'h5
`define DUHB_A_CTU       4'h6
`define DUHB_A_CTL       4'h7
`define DUHB_A_MODE_B    4'h8
`define DUHB_A_STAT_B    4'h9
`define DUHB_A_CMD_B     4'ha
`define DUHB_A_DATA_B    4'hb
`define DUHB_A_OUTPUT_PORT_CONFIG      4'hd
`define DUHB_A_IP_START  4'he
`define DUHB_A_OP_STOP   4'hf

// reset values
`define DUHB_RST_BYTE    8'h00
`define DUHB_RST_PINS    8'hff

// interrupt status bit positions driven onto alternate output pins
`define DUHB_ISR_TXA     0
`define DUHB_ISR_RXA     1
`define DUHB_ISR_TXB     4
`define DUHB_ISR_RXB     5

// output pin configuration bit positions
`define DUHB_OUTPUT_PORT_CONFIG_OP4    4
`define DUHB_OUTPUT_PORT_CONFIG_OP5    5
`define DUHB_OUTPUT_PORT_CONFIG_OP6    6
`define DUHB_OUTPUT_PORT_CONFIG_OP7    7

// input pin positions
`define DUHB_IP_CTS_A    0
`define DUHB_IP_CTS_B    1
`define DUHB_IP_CT_CLK   2
`define DUHB_IP_TXC_A    3
`define DUHB_IP_RXC_A    4
`define DUHB_IP_TXC_B    5

// mode register pointer values
`define DUHB_MRP_FIRST   1'b0
`define DUHB_MRP_SECOND  1'b1

`endif

// *** duhb_pkg.sv ***
// types for the dual serial controller host bus and pin map
// assumes duhb_params.svh is on the include path
package duhb_pkg;
  `include "duhb_params.svh"

  // host bus strobes
  typedef struct packed {
    logic       chip_select_n;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic [3:0] addr;
  } duhb_bus_t;

  // edges of external clock pins
  typedef struct packed {
    logic chan_a_tx_fall;
    logic chan_a_rx_rise;
    logic chan_b_tx_fall;
    logic ct_rise;
  } duhb_clk_ev_t;

  typedef enum logic [1:0] {
    DUHB_IDLE,
    DUHB_READ,
    DUHB_WRITE
  } duhb_bus_st_t;

  // whole module state
  typedef struct packed {
    duhb_bus_st_t st;
    duhb_bus_t    bus_q;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic [7:0]   in_s1;
    logic [7:0]   in_s2;
    logic [7:0]   in_prev;
    logic [7:0]   chan_a_status;
    logic [7:0]   chan_b_status;
    logic [7:0]   interrupt_mask;
    logic [7:0]   interrupt_status;
    logic [7:0]   output_port_value;
    logic [7:0]   output_port_config;
    logic         mode_reg_pointer_a;
    logic         mode_reg_pointer_b;
    logic         ct_running;
    logic         chan_a_active;
    logic         chan_b_active;
  } duhb_state_t;
endpackage

// *** duhb_host_port.sv ***
// host parallel bus port and pin function map of a dual serial controller
// assumes all inputs synchronous to clk; strobes are sampled, not used as clocks
//
// Behaviour
// - bus select high or open picks the separate read/write strobe protocol
// - eight-line tri-state data bus, line zero least significant
// - chip select high keeps data lines undriven
// - write data loads into addressed register on write strobe rising edge
// - read starts at read strobe falling edge, addressed register driven out
// - four address lines choose the register or port
// - reset clears both channel status, mask, status, output and config regs
// - reset drives general outputs high and stops the counter/timer
// - reset makes both channels inactive with serial outputs at mark
// - reset points each mode register pointer at the first mode register
// - interrupt request pulled low while any masked condition is true
// - output pin 7 alternate: open-drain low for channel B transmit status bit
// - input pin 0 general input or channel A clear-to-send
// - input pin 1 general input or channel B clear-to-send
// - input pin 2 general input or counter/timer clock
// - input pin 3 channel A transmit clock shifts on falling edge
// - input pin 4 channel A receive clock samples on rising edge
// - input pin 5 channel B transmit clock shifts on falling edge
`timescale 1ns/1ps
`include "duhb_params.svh"
module duhb_host_port
  import duhb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       bus_mode_sel,
  input  wire logic       chip_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic [6:0] in_pins,
  input  wire logic [7:0] irq_sources,
  input  wire logic [7:0] chan_a_status_in,
  input  wire logic [7:0] chan_b_status_in,
  output logic            irq_n_oe,
  output logic      [7:0] out_pins,
  output logic      [7:0] out_pins_oe,
  output logic            chan_a_serial_out,
  output logic            chan_b_serial_out,
  output logic            chan_a_clear_to_send_n,
  output logic            chan_b_clear_to_send_n,
  output logic            chan_a_tx_shift,
  output logic            chan_a_rx_sample,
  output logic            chan_b_tx_shift,
  output logic            ct_clock_tick,
  output logic            ct_running,
  output logic            chan_a_active,
  output logic            chan_b_active,
  output logic            mode_ptr_a,
  output logic            mode_ptr_b,
  output logic            wr_pulse,
  output logic      [3:0] wr_addr,
  output logic      [7:0] wr_data
);

  duhb_state_t  s_r;
  duhb_state_t  s_nxt;
  duhb_bus_t    bus_now;
  duhb_clk_ev_t ev;
  logic         strobe_mode;
  logic         rd_fall;
  logic         wr_rise;
  logic [7:0]   masked;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------

  // register value seen by a host read at a given address
  function automatic logic [7:0] read_mux(input duhb_state_t s, input logic [3:0] a);
    logic [7:0] v;
    v = `DUHB_RST_BYTE;
    if (a == `DUHB_A_STAT_A)
      v = s.chan_a_status;
    else if (a == `DUHB_A_STAT_B)
      v = s.chan_b_status;
    else if (a == `DUHB_A_ISR_IMR)
      v = s.interrupt_status;
    else if (a == `DUHB_A_IP_START)
      v = {1'b0, s.in_s2[6:0]};
    else if (a == `DUHB_A_OUTPUT_PORT_CONFIG)
      v = s.output_port_config;
    return v;
  endfunction

  // interrupt status bit shown on an alternate output pin
  function automatic int alt_bit(input int pin);
    int b;
    b = `DUHB_ISR_TXB;
    if (pin == `DUHB_OUTPUT_PORT_CONFIG_OP6)
      b = `DUHB_ISR_TXA;
    else if (pin == `DUHB_OUTPUT_PORT_CONFIG_OP5)
      b = `DUHB_ISR_RXB;
    else if (pin == `DUHB_OUTPUT_PORT_CONFIG_OP4)
      b = `DUHB_ISR_RXA;
    return b;
  endfunction

  // --------------------------------------------------------------
  // strobe edges and pin edges
  // --------------------------------------------------------------

  // strobe protocol chosen by the select input
  assign strobe_mode = bus_mode_sel;
  assign bus_now     = '{chip_select_n, write_strobe_n, read_strobe_n, addr};
  assign rd_fall     = strobe_mode && !bus_now.chip_select_n
                       && s_r.bus_q.read_strobe_n && !bus_now.read_strobe_n;
  assign wr_rise     = strobe_mode && s_r.st == DUHB_WRITE
                       && !s_r.bus_q.write_strobe_n && bus_now.write_strobe_n;

  // edges on synchronised external clock pins
  assign ev.chan_a_tx_fall = s_r.in_prev[`DUHB_IP_TXC_A] && !s_r.in_s2[`DUHB_IP_TXC_A];
  assign ev.chan_a_rx_rise = !s_r.in_prev[`DUHB_IP_RXC_A] && s_r.in_s2[`DUHB_IP_RXC_A];
  assign ev.chan_b_tx_fall = s_r.in_prev[`DUHB_IP_TXC_B] && !s_r.in_s2[`DUHB_IP_TXC_B];
  assign ev.ct_rise        = !s_r.in_prev[`DUHB_IP_CT_CLK] && s_r.in_s2[`DUHB_IP_CT_CLK];

  assign masked = s_r.interrupt_status & s_r.interrupt_mask;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------

  // bus sequencing and register updates
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.bus_q   = bus_now;
    s_nxt.in_s1   = {1'b0, in_pins};
    s_nxt.in_s2   = s_r.in_s1;
    s_nxt.in_prev = s_r.in_s2;
    s_nxt.chan_a_status    = chan_a_status_in;
    s_nxt.chan_b_status    = chan_b_status_in;
    s_nxt.interrupt_status = irq_sources;
    case (s_r.st)
      DUHB_IDLE:
      begin
        if (rd_fall)
        begin
          s_nxt.st    = DUHB_READ;
          s_nxt.rdata = read_mux(s_r, bus_now.addr);
        end
        else if (strobe_mode && !bus_now.chip_select_n && !bus_now.write_strobe_n)
          s_nxt.st = DUHB_WRITE;
      end
      DUHB_READ:
      begin
        if (bus_now.chip_select_n || bus_now.read_strobe_n)
          s_nxt.st = DUHB_IDLE;
      end
      DUHB_WRITE:
      begin
        s_nxt.wdata = bus_now.chip_select_n ? s_r.wdata : data_in;
        if (wr_rise)
        begin
          s_nxt.st = DUHB_IDLE;
          if (s_r.bus_q.addr == `DUHB_A_ISR_IMR)
            s_nxt.interrupt_mask = s_r.wdata;
          else if (s_r.bus_q.addr == `DUHB_A_OUTPUT_PORT_CONFIG)
            s_nxt.output_port_config = s_r.wdata;
          else if (s_r.bus_q.addr == `DUHB_A_IP_START)
            s_nxt.ct_running = 1'b1;
          else if (s_r.bus_q.addr == `DUHB_A_OP_STOP)
            s_nxt.ct_running = 1'b0;
          else if (s_r.bus_q.addr == `DUHB_A_MODE_A)
            s_nxt.mode_reg_pointer_a = `DUHB_MRP_SECOND;
          else if (s_r.bus_q.addr == `DUHB_A_MODE_B)
            s_nxt.mode_reg_pointer_b = `DUHB_MRP_SECOND;
          else if (s_r.bus_q.addr == `DUHB_A_CMD_A)
            s_nxt.chan_a_active = 1'b1;
          else if (s_r.bus_q.addr == `DUHB_A_CMD_B)
            s_nxt.chan_b_active = 1'b1;
        end
        else if (bus_now.chip_select_n)
          s_nxt.st = DUHB_IDLE;
      end
      default:
        s_nxt.st = DUHB_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------

  // synchronous reset to documented clear values
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r                    <= '0;
      s_r.st                 <= DUHB_IDLE;
      s_r.bus_q              <= '{1'b1, 1'b1, 1'b1, 4'h0};
      s_r.chan_a_status      <= `DUHB_RST_BYTE;
      s_r.chan_b_status      <= `DUHB_RST_BYTE;
      s_r.interrupt_mask     <= `DUHB_RST_BYTE;
      s_r.interrupt_status   <= `DUHB_RST_BYTE;
      s_r.output_port_value  <= `DUHB_RST_BYTE;
      s_r.output_port_config <= `DUHB_RST_BYTE;
      s_r.ct_running         <= 1'b0;
      s_r.chan_a_active      <= 1'b0;
      s_r.chan_b_active      <= 1'b0;
      s_r.mode_reg_pointer_a <= `DUHB_MRP_FIRST;
      s_r.mode_reg_pointer_b <= `DUHB_MRP_FIRST;
    end
    else
      s_r <= s_nxt;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------

  // data bus driven only during a selected read
  assign data_out = s_r.rdata;
  assign data_oe  = s_r.st == DUHB_READ && !chip_select_n && !read_strobe_n;

  // interrupt request, open drain
  assign irq_n_oe = |masked;

  // output pins: inverted port value, alternate functions open drain
  for (genvar p = 0; p < $bits(out_pins); p++)
  begin
    if (p < `DUHB_OUTPUT_PORT_CONFIG_OP4)
    begin
      assign out_pins[p]    = ~s_r.output_port_value[p];
      assign out_pins_oe[p] = 1'b1;
    end
    else
    begin
      assign out_pins[p]    = !s_r.output_port_config[p] && !s_r.output_port_value[p];
      assign out_pins_oe[p] = s_r.output_port_config[p] ? s_r.interrupt_status[alt_bit(p)]
                                                        : 1'b1;
    end
  end

  // serial outputs held at mark while inactive
  assign chan_a_serial_out = 1'b1;
  assign chan_b_serial_out = 1'b1;

  // alternate input functions
  assign chan_a_clear_to_send_n = s_r.in_s2[`DUHB_IP_CTS_A];
  assign chan_b_clear_to_send_n = s_r.in_s2[`DUHB_IP_CTS_B];
  assign chan_a_tx_shift        = ev.chan_a_tx_fall && s_r.chan_a_active;
  assign chan_a_rx_sample       = ev.chan_a_rx_rise && s_r.chan_a_active;
  assign chan_b_tx_shift        = ev.chan_b_tx_fall && s_r.chan_b_active;
  assign ct_clock_tick          = ev.ct_rise && s_r.ct_running;

  assign ct_running    = s_r.ct_running;
  assign chan_a_active = s_r.chan_a_active;
  assign chan_b_active = s_r.chan_b_active;
  assign mode_ptr_a    = s_r.mode_reg_pointer_a;
  assign mode_ptr_b    = s_r.mode_reg_pointer_b;

  // write notification to channel logic
  assign wr_pulse = wr_rise;
  assign wr_addr  = s_r.bus_q.addr;
  assign wr_data  = s_r.wdata;

endmodule

// *** duhb_chk.sv ***
// checker for the host bus port and pin map
// assumes binding onto duhb_host_port, one clock, sync reset
`timescale 1ns/1ps
module duhb_chk
  import duhb_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       bus_mode_sel,
  input wire logic       chip_select_n,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [6:0] in_pins,
  input wire logic [7:0] irq_sources,
  input wire logic       data_oe,
  input wire logic       irq_n_oe,
  input wire logic [7:0] out_pins,
  input wire logic [7:0] out_pins_oe,
  input wire logic       chan_a_serial_out,
  input wire logic       chan_b_serial_out,
  input wire logic       chan_a_clear_to_send_n,
  input wire logic       chan_b_clear_to_send_n,
  input wire logic       chan_a_tx_shift,
  input wire logic       chan_a_active,
  input wire logic       ct_running,
  input wire logic       mode_ptr_a,
  input wire logic       mode_ptr_b,
  input wire logic       wr_pulse
);
  // ----------------------------------------
  // bus, reset, pin and interrupt properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_fall;
    $fell(read_strobe_n) && !chip_select_n && bus_mode_sel;
  endsequence
  sequence s_rst_done;
    $rose(rst_n);
  endsequence
  a_rd_answer: assert property (s_rd_fall |=> data_oe)
    else $error("read not answered");
  a_cs_float: assert property (chip_select_n |-> !data_oe)
    else $error("data driven with chip select high");
  a_oe_read: assert property (data_oe |-> !read_strobe_n && bus_mode_sel)
    else $error("data driven outside read");
  a_rst_pins: assert property (s_rst_done |-> out_pins == 8'hff && out_pins_oe == 8'hff)
    else $error("outputs not high after reset");
  a_rst_idle: assert property (s_rst_done |->
    !(ct_running | chan_a_active | mode_ptr_a | mode_ptr_b | irq_n_oe))
    else $error("state not cleared by reset");
  a_tx_mark: assert property (chan_a_serial_out && chan_b_serial_out)
    else $error("serial output left mark");
  a_cts_sync: assert property ($past(rst_n) && $past(rst_n, 2) |->
    {chan_b_clear_to_send_n, chan_a_clear_to_send_n} == $past(in_pins[1:0], 2))
    else $error("clear to send not synchronised");
  a_txa_gate: assert property (chan_a_tx_shift |-> chan_a_active ##1 !chan_a_tx_shift)
    else $error("transmit shift pulse wrong");
  a_wr_edge: assert property (wr_pulse |-> write_strobe_n &&
    (!$past(write_strobe_n) || !$past(write_strobe_n, 2)) ##1 !wr_pulse)
    else $error("write without strobe rise");
  a_irq_src: assert property (irq_n_oe |-> |$past(irq_sources) || |$past(irq_sources, 2))
    else $error("interrupt without a source");
endmodule
bind duhb_host_port duhb_chk u_duhb_chk (.clk, .rst_n, .bus_mode_sel, .chip_select_n,
  .write_strobe_n, .read_strobe_n, .in_pins, .irq_sources, .data_oe, .irq_n_oe, .out_pins,
  .out_pins_oe, .chan_a_serial_out, .chan_b_serial_out, .chan_a_clear_to_send_n,
  .chan_b_clear_to_send_n, .chan_a_tx_shift, .chan_a_active, .ct_running, .mode_ptr_a,
  .mode_ptr_b, .wr_pulse);

// *** duhb_host_model.sv ***
// host processor model on the strobe bus
// assumes the bench calls its tasks; drives at falling clock edge
`timescale 1ns/1ps
module duhb_host_model
  import duhb_pkg::*;
(
  input  wire logic       clk,
  output logic            chip_select_n,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic      [3:0] addr,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  int hold = 2;
  // idle: deselected, strobes high
  initial
  begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    addr = 4'h0;
    data_in = 8'h00;
  end
  // write: strobe held low, data loads on its rise
  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    data_in = d;
    chip_select_n = 1'b0;
    write_strobe_n = 1'b0;
    repeat (hold) @(negedge clk);
    write_strobe_n = 1'b1;
    @(posedge clk);
    @(negedge clk);
    chip_select_n = 1'b1;
    data_in = ~d; // released lines show the inverse
    repeat (2) @(negedge clk);
  endtask
  // read: wait for the device to drive, take data at the next rising edge
  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    addr = a;
    @(negedge clk);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    for (int n = 0; n < 8 && data_oe !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    d = data_out;
    @(negedge clk);
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
endmodule

// *** duhb_host_port_tb_top.sv ***
// self-checking bench for the host bus port and pin map
// assumes duhb_chk bound, host model drives the bus
`timescale 1ns/1ps
module duhb_host_port_tb_top;
  import duhb_pkg::*;
  logic clk, rst_n, bus_mode_sel, chip_select_n, write_strobe_n, read_strobe_n, data_oe;
  logic irq_n_oe, chan_a_serial_out, chan_b_serial_out, ctsa_n, ctsb_n, chan_a_tx_shift;
  logic chan_a_rx_sample, chan_b_tx_shift, ct_clock_tick, ct_running, chan_a_active;
  logic chan_b_active, mode_ptr_a, mode_ptr_b, wr_pulse;
  logic [3:0] addr, wr_addr;
  logic [7:0] wr_data;
  logic [11:0] last_wr;
  logic [6:0] in_pins;
  logic [7:0] data_in, data_out, irq_sources, sta, stb, out_pins, out_pins_oe, v, m;
  logic [7:0] seed = 8'h0a;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         cnt [4] = '{default: 0};
  // ----------------------------------------
  // design, host and helpers
  // ----------------------------------------
  duhb_host_port u_duhb_host_port (.clk, .rst_n, .bus_mode_sel, .chip_select_n,
    .write_strobe_n, .read_strobe_n, .addr, .data_in, .data_out, .data_oe, .in_pins,
    .irq_sources, .chan_a_status_in(sta), .chan_b_status_in(stb), .irq_n_oe, .out_pins,
    .out_pins_oe, .chan_a_serial_out, .chan_b_serial_out, .chan_a_clear_to_send_n(ctsa_n),
    .chan_b_clear_to_send_n(ctsb_n), .chan_a_tx_shift, .chan_a_rx_sample, .chan_b_tx_shift,
    .ct_clock_tick, .ct_running, .chan_a_active, .chan_b_active, .mode_ptr_a, .mode_ptr_b,
    .wr_pulse, .wr_addr, .wr_data);
  duhb_host_model u_duhb_host_model (.clk, .chip_select_n, .write_strobe_n,
    .read_strobe_n, .addr, .data_in, .data_out, .data_oe);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one edge on an input pin should give exactly one pulse
  task automatic pin_edge(input int b, input logic rise, input int k);
    in_pins[b] = ~rise;
    repeat (5) @(negedge clk);
    cnt[k] = 0;
    in_pins[b] = rise;
    repeat (6) @(negedge clk);
    check(8'(cnt[k]), 8'h01);
  endtask
  task automatic summarize;
    $display("counts run=%0d bad=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cnt[0] += chan_a_tx_shift;
    cnt[1] += chan_a_rx_sample;
    cnt[2] += chan_b_tx_shift;
    cnt[3] += ct_clock_tick;
    if (wr_pulse)
      last_wr <= {wr_addr, wr_data};
  end
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {rst_n, bus_mode_sel, in_pins, irq_sources, sta, stb} = {2'b01, 31'h0};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check({chan_a_serial_out, chan_b_serial_out, chan_b_active, chan_a_active, ct_running,
      mode_ptr_b, mode_ptr_a, irq_n_oe}, 8'hc0);
    check(out_pins & out_pins_oe, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      u_duhb_host_model.hold = 2 + 3 * (i % 2);
      seed = lfsr(seed);
      m = (i == 0) ? 8'h00 : seed;
      seed = lfsr(seed);
      u_duhb_host_model.bus_write(4'h5, m);
      irq_sources = seed;
      repeat (4) @(negedge clk);
      check({7'h00, irq_n_oe}, {7'h00, |(m & seed)});
      u_duhb_host_model.bus_read(4'h5, v);
      check(v, seed);
    end
    bus_mode_sel = 1'b0;
    u_duhb_host_model.bus_write(4'h5, ~m);
    bus_mode_sel = 1'b1;
    irq_sources = 8'hff;
    repeat (4) @(negedge clk);
    check({7'h00, irq_n_oe}, {7'h00, |m});
    $display("test irq done");
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      {sta, stb, in_pins} = {seed, ~seed, seed[6:0]};
      u_duhb_host_model.bus_read(4'h1, v);
      check(v, seed);
      u_duhb_host_model.bus_read(4'h9, v);
      check(v, ~seed);
      u_duhb_host_model.bus_read(4'he, v);
      check(v, {1'b0, seed[6:0]});
      check({6'h00, ctsb_n, ctsa_n}, {6'h00, seed[1:0]});
    end
    u_duhb_host_model.bus_write(4'he, 8'h00);
    check({7'h00, ct_running}, 8'h01);
    pin_edge(2, 1'b1, 3);
    u_duhb_host_model.bus_write(4'h2, 8'h05);
    u_duhb_host_model.bus_write(4'ha, 8'h05);
    u_duhb_host_model.bus_write(4'h0, 8'h13);
    check({4'h0, chan_a_active, chan_b_active, mode_ptr_a, mode_ptr_b}, 8'h0e);
    check({4'h0, last_wr[11:8]}, 8'h00);
    check(last_wr[7:0], 8'h13);
    pin_edge(3, 1'b0, 0);
    pin_edge(4, 1'b1, 1);
    pin_edge(5, 1'b0, 2);
    u_duhb_host_model.bus_write(4'hf, 8'h00);
    check({7'h00, ct_running}, 8'h00);
    u_duhb_host_model.bus_write(4'h8, 8'h00);
    check({7'h00, mode_ptr_b}, 8'h01);
    $display("test pins done");
    u_duhb_host_model.bus_write(4'hd, 8'h80);
    u_duhb_host_model.bus_read(4'hd, v);
    check(v, 8'h80);
    for (int i = 0; i < 2; i++)
    begin
      irq_sources = {3'h0, i[0], 4'h0};
      repeat (4) @(negedge clk);
      check({out_pins[7], out_pins_oe[7], 6'h00}, {1'b0, i[0], 6'h00});
      check({1'b0, out_pins[6:0] & out_pins_oe[6:0]}, 8'h7f);
    end
    u_duhb_host_model.bus_write(4'he, 8'h00);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(out_pins, 8'hff);
    check(out_pins_oe, 8'hff);
    check({3'h0, chan_a_active, chan_b_active, ct_running, mode_ptr_a, mode_ptr_b}, 8'h00);
    $display("test op7 and second reset done");
    summarize();
  end
endmodule
